// ===== src/chg_i2c_params.svh
`ifndef CHG_I2C_PARAMS_SVH
`define CHG_I2C_PARAMS_SVH
// ==========================================================
// link constants
`define DEV_ADDR        7'h35
`define GEN_CALL_ADDR   7'h00
`define HS_CODE_PREFIX  5'h01
`define NUM_REGS        16
`define CLK_HZ          10000000
`define SCL_HZ_FAST     400000
`define SCL_HZ_STD      100000
// half period of scl made by the master, in clk cycles (least, rounds up)
`define SCL_HALF_CYC    ((`CLK_HZ + 2 * `SCL_HZ_STD - 1) / (2 * `SCL_HZ_STD))
`define PTR_RESET       8'h00
`endif

// ===== src/chg_i2c_pkg.sv
`default_nettype none
package chg_i2c_pkg;
   // ==========================================================
   // slave protocol states
   typedef enum logic [6:0] {
      S_IDLE = 7'b0000001,
      S_ADDR = 7'b0000010,
      S_AACK = 7'b0000100,
      S_RX   = 7'b0001000,
      S_RACK = 7'b0010000,
      S_TX   = 7'b0100000,
      S_TACK = 7'b1000000
   } slave_state_e;
   // master sequencer states
   typedef enum logic [5:0] {
      M_IDLE  = 6'b000001,
      M_START = 6'b000010,
      M_BIT   = 6'b000100,
      M_ACK   = 6'b001000,
      M_STOP  = 6'b010000,
      M_DONE  = 6'b100000
   } master_state_e;
endpackage
`default_nettype wire

// ===== src/i2c_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
   logic sclOut;
   logic sclOe;
   logic sdaMOut;
   logic sdaMOe;
   logic sdaSOut;
   logic sdaSOe;
   // open-drain wire levels: low wins when anyone drives
   logic scl;
   logic sda;
   assign scl = !(sclOe && !sclOut);
   assign sda = !((sdaMOe && !sdaMOut) || (sdaSOe && !sdaSOut));
   modport slave (input scl, input sda, output sdaSOut, output sdaSOe);
   modport master (input scl, input sda, output sclOut, output sclOe,
                   output sdaMOut, output sdaMOe);
endinterface
`default_nettype wire

// ===== src/charger_i2c_slave_port.sv
// How it works
// R01 - one bit per scl cycle, sda stable high
// R02 - start: sda falls, stop: sda rises, scl high
// R03 - both lines released while bus idle
// R04 - repeated start restarts address reception
// R05 - master may chain commands with repeated start
// R06 - after stop or mismatch ignore until start
// R07 - receiver pulls sda low for ninth bit
// R08 - nack means sda released on ninth bit
// R09 - master ends read with nack then stop
// R10 - answer only fixed seven bit address
// R11 - never hold scl low
// R12 - general call address never acknowledged
// R13 - works at any scl rate up to limit
// R14 - standard filters at power-up and every stop
// R15 - high-speed filters only after master code
// R16 - master treats nack as failure, retries; host port only reports it on doneNack, no retry
// R17 - slave only; receives writes, sends reads
// R18 - write: address, pointer, data, commit at ack
// R19 - sequential write commits each further byte
// R20 - read: pointer write, restart, read address
// R21 - master acks for more, nack ends read
// R22 - pointer advances after each data byte
`timescale 1ns/1ps
`default_nettype none
`include "chg_i2c_params.svh"
module charger_i2c_slave_port (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // link
   i2c_link_if.slave       link,
   // register file write side
   output logic            regWe,
   output logic [7:0]      regAddr,
   output logic [7:0]      regWdata,
   // register file read side, same clock
   input  wire logic [7:0] regRdata,
   // filter selection
   output logic            hsFilter
);
   // ==========================================================
   // pin synchronisers
   logic sclMeta_r, sclSync_r, sclDly_r;
   logic sdaMeta_r, sdaSync_r, sdaDly_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         sclMeta_r <= 1'b1;
         sclSync_r <= 1'b1;
         sclDly_r  <= 1'b1;
         sdaMeta_r <= 1'b1;
         sdaSync_r <= 1'b1;
         sdaDly_r  <= 1'b1;
      end else begin
         sclMeta_r <= link.scl;
         sclSync_r <= sclMeta_r;
         sclDly_r  <= sclSync_r;
         sdaMeta_r <= link.sda;
         sdaSync_r <= sdaMeta_r;
         sdaDly_r  <= sdaSync_r;
      end
   end

   // edge and bus condition detection, edge-based so any rate works [R13]
   logic sclRise, sclFall, startSeen, stopSeen;
   assign sclRise   = sclSync_r && !sclDly_r;
   assign sclFall   = !sclSync_r && sclDly_r;
   assign startSeen = sclSync_r && sclDly_r && sdaDly_r && !sdaSync_r; // [R02]
   assign stopSeen  = sclSync_r && sclDly_r && !sdaDly_r && sdaSync_r; // [R02]

   // ==========================================================
   // protocol engine
   chg_i2c_pkg::slave_state_e state_r;
   logic [7:0] shift_r;
   logic [3:0] bitCnt_r;
   logic       ptrPhase_r;   // next written byte is the pointer
   logic       ackDrive_r;   // this ninth bit gets our ack
   logic       masterNack_r;
   logic       hsArm_r;      // master code seen, switch at stop-free restart
   logic [7:0] ptr_r;
   logic       sdaOut_r;
   logic       sdaOe_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r      <= chg_i2c_pkg::S_IDLE;
         shift_r      <= 8'h00;
         bitCnt_r     <= 4'h0;
         ptrPhase_r   <= 1'b0;
         ackDrive_r   <= 1'b0;
         masterNack_r <= 1'b0;
         hsArm_r      <= 1'b0;
         ptr_r        <= `PTR_RESET;
         regWe        <= 1'b0;
         regAddr      <= 8'h00;
         regWdata     <= 8'h00;
         hsFilter     <= 1'b0;
      end else begin
         regWe   <= 1'b0;
         regAddr <= ptr_r; // read port follows the pointer [R20] [R22]
         if (stopSeen) begin
            state_r  <= chg_i2c_pkg::S_IDLE; // [R06]
            hsFilter <= 1'b0;                // [R14]
            hsArm_r  <= 1'b0;
         end else if (startSeen) begin
            // repeated start handled the same as start [R04]
            state_r  <= chg_i2c_pkg::S_ADDR;
            bitCnt_r <= 4'h0;
            if (hsArm_r) begin
               hsFilter <= 1'b1; // [R15]
            end
         end else begin
            unique case (state_r)
               chg_i2c_pkg::S_IDLE: begin
                  // scl ignored here until the next start [R06]
               end
               chg_i2c_pkg::S_ADDR, chg_i2c_pkg::S_RX: begin
                  if (sclRise) begin // sample at high phase [R01]
                     shift_r  <= {shift_r[6:0], sdaSync_r};
                     bitCnt_r <= bitCnt_r + 4'h1;
                  end else if (sclFall && bitCnt_r == 4'h8) begin
                     bitCnt_r <= 4'h0;
                     if (state_r == chg_i2c_pkg::S_ADDR) begin
                        state_r <= chg_i2c_pkg::S_AACK;
                        ackDrive_r <= (shift_r[7:1] == `DEV_ADDR); // [R10]
                        // general call and others never answered [R12]
                        if (shift_r[7:3] == `HS_CODE_PREFIX) begin
                           hsArm_r <= 1'b1; // master code [R15]
                        end
                        if (shift_r[7:1] == `DEV_ADDR && !shift_r[0]) begin
                           ptrPhase_r <= 1'b1;
                        end
                     end else begin
                        state_r    <= chg_i2c_pkg::S_RACK;
                        ackDrive_r <= 1'b1; // [R07]
                     end
                  end
               end
               chg_i2c_pkg::S_AACK: begin
                  if (sclFall) begin
                     if (!ackDrive_r) begin
                        state_r <= chg_i2c_pkg::S_IDLE; // [R06]
                     end else if (shift_r[0]) begin
                        state_r  <= chg_i2c_pkg::S_TX; // [R17] [R20]
                        shift_r  <= regRdata;
                        bitCnt_r <= 4'h0;
                     end else begin
                        state_r <= chg_i2c_pkg::S_RX;
                     end
                     ackDrive_r <= 1'b0;
                  end
               end
               chg_i2c_pkg::S_RACK: begin
                  if (sclRise) begin
                     if (ptrPhase_r) begin
                        ptr_r      <= shift_r;
                        ptrPhase_r <= 1'b0;
                     end else begin
                        // commit on the ack clock's rising edge [R18] [R19]
                        regWe    <= 1'b1;
                        regAddr  <= ptr_r;
                        regWdata <= shift_r;
                        ptr_r    <= ptr_r + 8'h01; // [R22]
                     end
                  end else if (sclFall) begin
                     state_r    <= chg_i2c_pkg::S_RX;
                     ackDrive_r <= 1'b0;
                  end
               end
               chg_i2c_pkg::S_TX: begin
                  if (sclFall) begin
                     if (bitCnt_r == 4'h7) begin
                        state_r  <= chg_i2c_pkg::S_TACK;
                        bitCnt_r <= 4'h0;
                        ptr_r    <= ptr_r + 8'h01; // [R22]
                     end else begin
                        shift_r  <= {shift_r[6:0], 1'b0};
                        bitCnt_r <= bitCnt_r + 4'h1;
                     end
                  end
               end
               chg_i2c_pkg::S_TACK: begin
                  if (sclRise) begin
                     masterNack_r <= sdaSync_r;
                  end else if (sclFall) begin
                     if (masterNack_r) begin
                        state_r <= chg_i2c_pkg::S_IDLE; // [R21]
                     end else begin
                        state_r <= chg_i2c_pkg::S_TX;
                        shift_r <= regRdata;
                     end
                  end
               end
            endcase
         end
      end
   end

   // read port points at the current register
   // (regAddr doubles as the read address outside writes)

   // ==========================================================
   // sda drive: only while scl is low are changes made [R01]
   always_ff @(posedge clk) begin
      if (rst) begin
         sdaOut_r <= 1'b1;
         sdaOe_r  <= 1'b0; // released from reset [R03]
      end else if (startSeen || stopSeen) begin
         sdaOut_r <= 1'b1;
         sdaOe_r  <= 1'b0;
      end else if (sclFall) begin
         sdaOut_r <= 1'b1;
         sdaOe_r  <= 1'b0;
         if (state_r == chg_i2c_pkg::S_ADDR && bitCnt_r == 4'h8 &&
             shift_r[7:1] == `DEV_ADDR) begin
            sdaOut_r <= 1'b0; // address ack [R07] [R10]
            sdaOe_r  <= 1'b1;
         end else if (state_r == chg_i2c_pkg::S_RX && bitCnt_r == 4'h8) begin
            sdaOut_r <= 1'b0; // data ack [R07]
            sdaOe_r  <= 1'b1;
         end else if (state_r == chg_i2c_pkg::S_AACK && ackDrive_r &&
                      shift_r[0]) begin
            sdaOut_r <= regRdata[7];
            sdaOe_r  <= !regRdata[7];
         end else if (state_r == chg_i2c_pkg::S_TX && bitCnt_r != 4'h7) begin
            sdaOut_r <= shift_r[6];
            sdaOe_r  <= !shift_r[6];
         end else if (state_r == chg_i2c_pkg::S_TACK && !masterNack_r) begin
            sdaOut_r <= regRdata[7];
            sdaOe_r  <= !regRdata[7];
         end
         // nack: ninth bit left released [R08] [R21]
      end
   end
   assign link.sdaSOut = sdaOut_r;
   assign link.sdaSOe  = sdaOe_r; // no scl driver exists here [R11] [R17]
endmodule
`default_nettype wire

// ===== src/charger_i2c_host_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "chg_i2c_params.svh"
module charger_i2c_host_port (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // link
   i2c_link_if.master      link,
   // byte command: start bit, stop bit, read bit, ack to send
   input  wire logic       cmdValid,
   input  wire logic       cmdStart,
   input  wire logic       cmdStop,
   input  wire logic       cmdRead,
   input  wire logic       cmdNack,
   input  wire logic [7:0] cmdData,
   // answer
   output logic            cmdReady,
   output logic            doneValid,
   output logic [7:0]      doneData,
   output logic            doneNack
);
   // ==========================================================
   // scl phase divider: one enable per quarter bit
   localparam logic [7:0] QUARTER = 8'((`SCL_HALF_CYC + 1) / 2);
   logic [7:0] div_r;
   logic       tick;
   always_ff @(posedge clk) begin
      if (rst || div_r == QUARTER - 8'h01) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end
   assign tick = (div_r == QUARTER - 8'h01);

   // ==========================================================
   // sda pin synchroniser; ph2 samples long after the bit settles
   logic sdaMeta_r, sdaSync_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         sdaMeta_r <= 1'b1;
         sdaSync_r <= 1'b1;
      end else begin
         sdaMeta_r <= link.sda;
         sdaSync_r <= sdaMeta_r;
      end
   end

   // ==========================================================
   // sequencer: phases 0 low, 1 low, 2 high sample, 3 high
   chg_i2c_pkg::master_state_e st_r;
   logic [1:0] ph_r;
   logic [2:0] bit_r;
   logic [7:0] sh_r;
   logic       rd_r, nack_r, stop_r;
   logic       sclO_r, sdaO_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= chg_i2c_pkg::M_IDLE;
         ph_r <= 2'd0;
         bit_r <= 3'd0;
         sh_r <= 8'h00;
         rd_r <= 1'b0;
         nack_r <= 1'b0;
         stop_r <= 1'b0;
         sclO_r <= 1'b1; // bus rests high [R03]
         sdaO_r <= 1'b1;
         cmdReady <= 1'b0;
         doneValid <= 1'b0;
         doneData <= 8'h00;
         doneNack <= 1'b0;
      end else begin
         doneValid <= 1'b0;
         cmdReady  <= (st_r == chg_i2c_pkg::M_IDLE) && !cmdReady && !cmdValid;
         unique case (st_r)
            chg_i2c_pkg::M_IDLE: begin
               if (cmdValid) begin
                  sh_r <= cmdData;
                  rd_r <= cmdRead;
                  nack_r <= cmdNack; // final read byte gets nack [R09]
                  stop_r <= cmdStop;
                  bit_r <= 3'd0;
                  ph_r <= 2'd0;
                  cmdReady <= 1'b0;
                  // start or repeated start [R02] [R05]
                  st_r <= cmdStart ? chg_i2c_pkg::M_START
                                   : chg_i2c_pkg::M_BIT;
               end
            end
            chg_i2c_pkg::M_START: if (tick) begin
               ph_r <= ph_r + 2'd1;
               unique case (ph_r)
                  2'd0: sdaO_r <= 1'b1;
                  2'd1: sclO_r <= 1'b1;
                  2'd2: sdaO_r <= 1'b0; // falls with scl high [R02]
                  2'd3: begin
                     sclO_r <= 1'b0;
                     st_r <= chg_i2c_pkg::M_BIT;
                  end
               endcase
            end
            chg_i2c_pkg::M_BIT, chg_i2c_pkg::M_ACK: if (tick) begin
               ph_r <= ph_r + 2'd1;
               unique case (ph_r)
                  2'd0: begin // change sda only while low [R01]
                     if (st_r == chg_i2c_pkg::M_BIT) begin
                        sdaO_r <= rd_r ? 1'b1 : sh_r[7];
                     end else begin
                        sdaO_r <= rd_r ? nack_r : 1'b1; // [R21]
                     end
                  end
                  2'd1: sclO_r <= 1'b1;
                  2'd2: begin
                     if (st_r == chg_i2c_pkg::M_BIT) begin
                        sh_r <= {sh_r[6:0], sdaSync_r};
                     end else begin
                        doneNack <= rd_r ? nack_r : sdaSync_r; // [R16]
                     end
                  end
                  2'd3: begin
                     sclO_r <= 1'b0;
                     if (st_r == chg_i2c_pkg::M_ACK) begin
                        doneData <= sh_r;
                        st_r <= stop_r ? chg_i2c_pkg::M_STOP
                                       : chg_i2c_pkg::M_DONE;
                     end else if (bit_r == 3'd7) begin
                        st_r <= chg_i2c_pkg::M_ACK;
                     end else begin
                        bit_r <= bit_r + 3'd1;
                     end
                  end
               endcase
            end
            chg_i2c_pkg::M_STOP: if (tick) begin
               ph_r <= ph_r + 2'd1;
               unique case (ph_r)
                  2'd0: sdaO_r <= 1'b0;
                  2'd1: sclO_r <= 1'b1;
                  2'd2: sdaO_r <= 1'b1; // rises with scl high [R02]
                  2'd3: st_r <= chg_i2c_pkg::M_DONE;
               endcase
            end
            chg_i2c_pkg::M_DONE: begin
               doneValid <= 1'b1;
               st_r <= chg_i2c_pkg::M_IDLE;
            end
            default: st_r <= chg_i2c_pkg::M_IDLE;
         endcase
      end
   end
   // open-drain: drive only lows, release highs [R03]
   assign link.sclOut  = 1'b0;
   assign link.sclOe   = !sclO_r;
   assign link.sdaMOut = 1'b0;
   assign link.sdaMOe  = !sdaO_r;
endmodule
`default_nettype wire

// ===== verification/charger_i2c_slave_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "chg_i2c_params.svh"
module charger_i2c_slave_port_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // link drivers and resolved wires
   input wire logic sclOut,
   input wire logic sclOe,
   input wire logic sdaMOut,
   input wire logic sdaMOe,
   input wire logic sdaSOut,
   input wire logic sdaSOe,
   input wire logic scl,
   input wire logic sda
);
   // ==========
   // bus events seen straight on the wires
   logic       slvLow, mstLow, sclRise, start, stop;
   logic       addrAck, dataAck, addrHit;
   logic       sclQ_r, sdaQ_r, first_r, wr_r, rd_r;
   logic       miss_r, idle_r, endRd_r;
   logic [3:0] bitCnt_r;
   logic [7:0] shift_r;
   assign slvLow  = sdaSOe && !sdaSOut;
   assign mstLow  = sdaMOe && !sdaMOut;
   assign sclRise = scl && !sclQ_r;
   assign start   = scl && sclQ_r && sdaQ_r && !sda;
   assign stop    = scl && sclQ_r && !sdaQ_r && sda;
   assign addrAck = sclRise && bitCnt_r == 4'h8 && first_r;
   assign dataAck = sclRise && bitCnt_r == 4'h8 && !first_r;
   assign addrHit = shift_r[7:1] == `DEV_ADDR;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // wire history, one clk back
   always_ff @(posedge clk) begin
      sclQ_r <= scl;
      sdaQ_r <= sda;
   end
   // bit position in the byte; the ninth rise is the ack slot
   always_ff @(posedge clk) begin
      if (rst || start) begin
         bitCnt_r <= 4'h0;
         first_r  <= 1'b1;
      end else if (sclRise) begin
         bitCnt_r <= (bitCnt_r == 4'h8) ? 4'h0 : bitCnt_r + 4'h1;
         if (bitCnt_r == 4'h8) first_r <= 1'b0;
         if (bitCnt_r != 4'h8) shift_r <= {shift_r[6:0], sda};
      end
   end
   // direction fixed by the address byte, dropped at any condition
   always_ff @(posedge clk) begin
      if (rst || start || stop) begin
         wr_r <= 1'b0;
         rd_r <= 1'b0;
      end else if (addrAck && addrHit) begin
         wr_r <= !shift_r[0];
         rd_r <= shift_r[0];
      end
   end
   // quiet periods: foreign address, ended read, idle bus
   always_ff @(posedge clk) begin
      if (rst || start) begin
         miss_r  <= 1'b0;
         endRd_r <= 1'b0;
      end else begin
         if (addrAck && !addrHit) miss_r <= 1'b1;
         if (dataAck && rd_r && sda) endRd_r <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst || stop) idle_r <= 1'b1;
      else if (start) idle_r <= 1'b0;
   end
   // ==========
   // assertions
   chk_addr_ack: assert property (addrAck |-> slvLow == addrHit)
      else $error("address ack does not match own address");
   chk_write_ack: assert property (dataAck && wr_r |-> slvLow)
      else $error("written byte not acknowledged");
   chk_read_free: assert property (dataAck && rd_r |-> !slvLow)
      else $error("slave holds sda in master ack slot");
   chk_miss_quiet: assert property (miss_r |-> !slvLow)
      else $error("slave drives sda after foreign address");
   chk_idle_quiet: assert property (idle_r |-> !slvLow)
      else $error("slave drives sda while bus idle");
   chk_read_end: assert property (endRd_r |=> !slvLow)
      else $error("slave drives sda after read nack");
   chk_sda_stable: assert property (scl && sclQ_r |-> $stable(slvLow))
      else $error("slave changes sda while scl high");
   chk_master_start: assert property (
      $fell(sda) && scl && sclQ_r |-> mstLow)
      else $error("start condition not made by master");
   // main scenarios reached
   cover property (dataAck && wr_r);
   cover property (dataAck && rd_r && sda);
   cover property (addrAck && !addrHit);
endmodule
`default_nettype wire

// ===== verification/test_charger_i2c_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "chg_i2c_params.svh"
module test_charger_i2c_slave_port;
   // ==========
   // clock, reset, wiring
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       cmdValid, cmdStart, cmdStop, cmdRead, cmdNack;
   logic       cmdReady, doneValid, doneNack, regWe, hsFilter, gotNack;
   logic [7:0] cmdData, doneData, regAddr, regWdata, regRdata, gotData;
   logic [7:0] regMem [16];
   logic [7:0] expMem [16];
   int         error_cnt = 0;
   int         checks = 0;
   int         seed = 37;
   int         weCnt = 0;
   always #50 clk = ~clk;
   i2c_link_if link ();
   charger_i2c_slave_port u_charger_i2c_slave_port (.clk(clk), .rst(rst),
      .link(link), .regWe(regWe), .regAddr(regAddr), .regWdata(regWdata),
      .regRdata(regRdata), .hsFilter(hsFilter));
   charger_i2c_host_port u_charger_i2c_host_port (.clk(clk), .rst(rst),
      .link(link), .cmdValid(cmdValid), .cmdStart(cmdStart),
      .cmdStop(cmdStop), .cmdRead(cmdRead), .cmdNack(cmdNack),
      .cmdData(cmdData), .cmdReady(cmdReady), .doneValid(doneValid),
      .doneData(doneData), .doneNack(doneNack));
   charger_i2c_slave_port_chk u_chk (.clk(clk), .rst(rst),
      .sclOut(link.sclOut), .sclOe(link.sclOe), .sdaMOut(link.sdaMOut),
      .sdaMOe(link.sdaMOe), .sdaSOut(link.sdaSOut), .sdaSOe(link.sdaSOe),
      .scl(link.scl), .sda(link.sda));
   // register file behind the slave; reads follow the pointer
   assign regRdata = regMem[regAddr[3:0]];
   always @(posedge clk) begin
      if (regWe === 1'b1) begin
         regMem[regAddr[3:0]] <= regWdata;
         weCnt++;
      end
   end
   // ==========
   // reporting
   task test_done;
      $display("errors %0d, checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task cmp1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // ==========
   // one byte through the host port; waits are bounded
   task xfer(input logic s, input logic p, input logic r, input logic k,
             input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      while (cmdReady !== 1'b1) begin
         n++;
         if (n > 2000) begin
            cmp1(1'b0, 1'b1);
            test_done;
         end
         @(posedge clk);
      end
      {cmdValid, cmdStart, cmdStop, cmdRead, cmdNack, cmdData} <=
         {1'b1, s, p, r, k, d};
      @(posedge clk);
      cmdValid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (n > 3000) begin
            cmp1(1'b0, 1'b1);
            test_done;
         end
      end while (doneValid !== 1'b1);
      gotData = doneData;
      gotNack = doneNack;
   endtask
   // pointer then n data bytes; no stop leaves room for a repeated start
   task wr(input logic [7:0] p, input int n, input logic stp);
      logic [7:0] d;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {`DEV_ADDR, 1'b0});
      cmp1(gotNack, 1'b0);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, p);
      cmp1(gotNack, 1'b0);
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         xfer(1'b0, stp && i == n - 1, 1'b0, 1'b0, d);
         cmp1(gotNack, 1'b0);
         expMem[p[3:0] + i] = d;
      end
      for (int i = 0; i < n; i++)
         cmp8(regMem[p[3:0] + i], expMem[p[3:0] + i]);
   endtask
   // pointer write, repeated start, n bytes, nack and stop on the last
   task rd(input logic [7:0] p, input int n);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {`DEV_ADDR, 1'b0});
      cmp1(gotNack, 1'b0);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, p);
      cmp1(gotNack, 1'b0);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {`DEV_ADDR, 1'b1});
      cmp1(gotNack, 1'b0);
      for (int i = 0; i < n; i++) begin
         xfer(1'b0, i == n - 1, 1'b1, i == n - 1, 8'h00);
         cmp8(gotData, expMem[p[3:0] + i]);
      end
   endtask
   // foreign address: no ack, following byte ignored, nothing written
   task bad(input logic [7:0] a);
      int w;
      w = weCnt;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, a);
      cmp1(gotNack, 1'b1);
      xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h5a);
      cmp1(gotNack, 1'b1);
      cmp8(8'(weCnt - w), 8'h00);
   endtask
   // ==========
   // main sequence
   initial begin
      logic [7:0] p;
      logic [7:0] a;
      int         n;
      {cmdValid, cmdStart, cmdStop, cmdRead, cmdNack, cmdData} = '0;
      for (int i = 0; i < 16; i++) begin
         regMem[i] = 8'($random(seed));
         expMem[i] = regMem[i];
      end
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      cmp1(hsFilter, 1'b0);
      // corners: top register, chained commands, general call
      wr(8'h0f, 1, 1'b1);
      wr(8'h00, 4, 1'b0);
      rd(8'h00, 4);
      rd(8'h0f, 1);
      bad({`GEN_CALL_ADDR, 1'b0});
      bad({`GEN_CALL_ADDR, 1'b1});
      bad(8'h68);
      bad(8'h6d);
      // master code arms, repeated start selects, stop clears
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {`HS_CODE_PREFIX, 3'h2});
      cmp1(gotNack, 1'b1);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {`DEV_ADDR, 1'b0});
      cmp1(gotNack, 1'b0);
      cmp1(hsFilter, 1'b1);
      xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h03);
      repeat (4) @(posedge clk);
      cmp1(hsFilter, 1'b0);
      // random mix of writes, reads and foreign addresses
      for (int k = 0; k < 6; k++) begin
         n = 1 + ($unsigned($random(seed)) % 3);
         p = {4'h0, 4'($random(seed))};
         if (p > 16 - n) p = 8'(16 - n);
         a = 8'($random(seed));
         if (a[7:1] == `DEV_ADDR) a = a ^ 8'h02;
         case ($unsigned($random(seed)) % 3)
            0: wr(p, n, 1'b1);
            1: rd(p, n);
            default: bad(a);
         endcase
      end
      test_done;
   end
endmodule
`default_nettype wire
